// ---- core/pscl_ctrl.sv ----
// bus master that writes the filter drive latch and probes option presence
`timescale 1ns/10ps
`include "pscl_defs.svh"
module pscl_ctrl
#(
  parameter int RELAY_CYCLES = `PSCL_N_RELAY
)
(
  input  wire logic       clock,
  input  wire logic       rst,
  // user side
  input  wire logic       applyReq,
  input  wire logic [2:0] band,
  input  wire logic       filterUsed,
  input  wire logic       degauss,
  input  wire logic       narrowSpan,
  input  wire logic       filterSwept,
  input  wire logic       lowPass,
  input  wire logic       probeReq,
  output logic            busy,
  output logic            doneOut,
  output logic            optionFitted,
  output logic            optionValid,
  output logic            relayPulse,
  // device bus
  output logic      [7:0] busAddr,
  output logic      [7:0] busDataOut,
  output logic            busDataOe,
  input  wire logic [7:0] busDataIn,
  output logic            busWrStrobe_n,
  output logic            busRdStrobe_n
);
  localparam int NSET = `PSCL_N_SETUP;
  localparam int NSTB = `PSCL_N_STROBE;

  pscl_pkg::pscl_state_t state_ff;       // sequencer state
  logic [7:0]            cnt_ff;         // phase counter
  logic                  isRead_ff;      // current cycle is a probe
  logic [7:0]            latchByte;      // encoded byte
  logic [7:0]            busAddr_ff;     // address register
  logic [7:0]            busData_ff;     // write data register
  logic                  busOe_ff;       // data drive enable
  logic                  wrN_ff;         // write strobe, active low
  logic                  rdN_ff;         // read strobe, active low
  logic                  done_ff;        // done pulse
  logic                  optFit_ff;      // option fitted
  logic                  optVal_ff;      // option result valid
  logic                  d4Sync1_ff;     // option line synchroniser first stage
  logic                  d4Sync2_ff;     // option line synchroniser second stage
  logic                  lastPath_ff;    // filter path last written
  logic                  pathKnown_ff;   // a path has been written
  logic [31:0]           relayCnt_ff;    // relay pulse timer
  logic                  relay_ff;       // relay pulse output
  logic                  busy_ff;        // a bus cycle is running
  logic                  wrEdge;         // this edge raises the write strobe

  //////////////////////////////////////////////////////////////////////////////
  // encoder for the latch byte
  pscl_latch_encode u_enc
  (
    .band        (band),
    .filterUsed  (filterUsed),
    .degauss     (degauss),
    .narrowSpan  (narrowSpan),
    .filterSwept (filterSwept),
    .lowPass     (lowPass),
    .latchByte   (latchByte)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus cycle sequencer: setup, strobe low, strobe rise, hold
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_ff   <= pscl_pkg::PSCL_IDLE;
      cnt_ff     <= 8'h00;
      isRead_ff  <= 1'b0;
      busAddr_ff <= 8'h00;
      busData_ff <= 8'h00;
      busOe_ff   <= 1'b0;
      wrN_ff     <= 1'b1;
      rdN_ff     <= 1'b1;
      done_ff    <= 1'b0;
      busy_ff    <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      case (state_ff)
        pscl_pkg::PSCL_IDLE:
        begin
          // writes take priority over probes
          if (applyReq)
          begin
            busAddr_ff <= `PSCL_ADDR_LATCH; // RULE1
            busData_ff <= latchByte; // RULE2
            busOe_ff   <= 1'b1;
            busy_ff    <= 1'b1;
            isRead_ff  <= 1'b0;
            cnt_ff     <= 8'h00;
            state_ff   <= pscl_pkg::PSCL_SETUP;
          end
          else if (probeReq)
          begin
            busAddr_ff <= `PSCL_ADDR_OPTION; // RULE1
            busOe_ff   <= 1'b0; // RULE4
            busy_ff    <= 1'b1;
            isRead_ff  <= 1'b1;
            cnt_ff     <= 8'h00;
            state_ff   <= pscl_pkg::PSCL_SETUP;
          end
        end
        pscl_pkg::PSCL_SETUP:
        begin
          // address and data settle before the strobe
          if (cnt_ff == 8'(NSET - 1))
          begin
            cnt_ff   <= 8'h00;
            wrN_ff   <= isRead_ff;
            rdN_ff   <= !isRead_ff;
            state_ff <= pscl_pkg::PSCL_STROBE;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        pscl_pkg::PSCL_STROBE:
        begin
          // strobe rise is the latch edge; data still held
          if (cnt_ff == 8'(NSTB - 1))
          begin
            cnt_ff   <= 8'h00;
            wrN_ff   <= 1'b1; // RULE2
            rdN_ff   <= 1'b1;
            state_ff <= pscl_pkg::PSCL_HOLD;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        pscl_pkg::PSCL_HOLD:
        begin
          // one setup time of hold, then release the bus
          if (cnt_ff == 8'(NSET - 1))
          begin
            busOe_ff <= 1'b0;
            state_ff <= pscl_pkg::PSCL_DONE;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        pscl_pkg::PSCL_DONE:
        begin
          // one cycle only: pulse done, clear busy and return to idle
          done_ff  <= 1'b1;
          busy_ff  <= 1'b0;
          state_ff <= pscl_pkg::PSCL_IDLE;
        end
        default:
        begin
          // stray state: drop back to idle, not busy
          busy_ff  <= 1'b0;
          state_ff <= pscl_pkg::PSCL_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // option line synchroniser
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      d4Sync1_ff <= 1'b1;
      d4Sync2_ff <= 1'b1;
    end
    else
    begin
      d4Sync1_ff <= busDataIn[`PSCL_BIT_OPTION_FLAG];
      d4Sync2_ff <= d4Sync1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // option result: sampled at end of read strobe, low means fitted
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      optFit_ff <= 1'b0;
      optVal_ff <= 1'b0;
    end
    else if (isRead_ff && (state_ff == pscl_pkg::PSCL_STROBE) && (cnt_ff == 8'(NSTB - 1)))
    begin
      optFit_ff <= !d4Sync2_ff; // RULE3
      optVal_ff <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // relay pulse timer, retriggered by a written change of filter path
  // the write edge is the same edge at which the device latches the byte
  assign wrEdge = !isRead_ff && (state_ff == pscl_pkg::PSCL_STROBE) && (cnt_ff == 8'(NSTB - 1));

  // a write that keeps the path must not stall the running countdown
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lastPath_ff  <= 1'b0;
      pathKnown_ff <= 1'b0;
      relayCnt_ff  <= 32'h00000000;
      relay_ff     <= 1'b0;
    end
    else
    begin
      // remember the path that was written
      if (wrEdge)
      begin
        lastPath_ff  <= busData_ff[`PSCL_BIT_FILT_PATH];
        pathKnown_ff <= 1'b1;
      end
      // first or changed path reloads, otherwise count down
      if (wrEdge && (!pathKnown_ff || (busData_ff[`PSCL_BIT_FILT_PATH] != lastPath_ff)))
      begin
        relayCnt_ff <= 32'(RELAY_CYCLES); // RULE16
        relay_ff    <= 1'b1;
      end
      else if (relayCnt_ff > 32'h00000001)
        relayCnt_ff <= relayCnt_ff - 32'h00000001;
      else
      begin
        relayCnt_ff <= 32'h00000000;
        relay_ff    <= 1'b0; // RULE16
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign busAddr       = busAddr_ff;
  assign busDataOut    = busData_ff;
  assign busDataOe     = busOe_ff;
  assign busWrStrobe_n = wrN_ff;
  assign busRdStrobe_n = rdN_ff;
  assign busy          = busy_ff;
  assign doneOut       = done_ff;
  assign optionFitted  = optFit_ff;
  assign optionValid   = optVal_ff;
  assign relayPulse    = relay_ff;
endmodule

// ---- core/pscl_defs.svh ----
// offsets, latch bit positions and timing counts for the filter drive latch controller
// How it works
// (RULE1) write 77h loads latch; read F7h checks option
// (RULE2) latch takes all eight bits on strobe end
// (RULE3) option fitted when data bit 4 reads low
// (RULE4) only data bit 4 driven during option read
// (RULE5) gain bit high unity, low gain three
// (RULE6) select gain three in bands 4 and 5
// (RULE7) drive enable bit high connects coil driver
// (RULE8) drop drive enable when unused or degaussing
// (RULE9) sweep inject bit set for narrow-coil spans
// (RULE10) filter path bit high low-pass, low tracking
// (RULE11) output filter bit low unless filter swept
// (RULE12) negative offset bit high adds minus 829 MHz
// (RULE13) positive offset bit high adds plus 829 MHz
// (RULE14) never both offset bits set together
// (RULE15) both offset bits clear for 2072 MHz IF
// (RULE16) filter path change fires about 100 ms pulse
`ifndef PSCL_DEFS_SVH
`define PSCL_DEFS_SVH
`define PSCL_ADDR_LATCH      8'h77
`define PSCL_ADDR_OPTION     8'hF7
`define PSCL_BIT_GAIN        0
`define PSCL_BIT_DRIVE_EN    2
`define PSCL_BIT_SWEEP_INJ   3
`define PSCL_BIT_FILT_PATH   4
`define PSCL_BIT_OUT_FILT    5
`define PSCL_BIT_NEG_IF      6
`define PSCL_BIT_POS_IF      7
`define PSCL_BIT_OPTION_FLAG 4
`define PSCL_LATCH_DEFAULT   8'h20
`define PSCL_CLK_MHZ         250
`define PSCL_T_SETUP_NS      8
`define PSCL_N_SETUP         ((`PSCL_T_SETUP_NS * `PSCL_CLK_MHZ + 999) / 1000)
`define PSCL_T_STROBE_NS     40
`define PSCL_N_STROBE        ((`PSCL_T_STROBE_NS * `PSCL_CLK_MHZ + 999) / 1000)
`define PSCL_T_RELAY_MS      100
`define PSCL_N_RELAY         (`PSCL_T_RELAY_MS * `PSCL_CLK_MHZ * 1000)
`endif

// ---- core/pscl_latch_encode.sv ----
// builds the latch byte from the user's operating settings
`timescale 1ns/10ps
`include "pscl_defs.svh"
module pscl_latch_encode
(
  input  wire logic [2:0] band,
  input  wire logic       filterUsed,
  input  wire logic       degauss,
  input  wire logic       narrowSpan,
  input  wire logic       filterSwept,
  input  wire logic       lowPass,
  output logic      [7:0] latchByte
);
  //////////////////////////////////////////////////////////////////////////////
  // combinational mapping of settings to bits
  always_comb
  begin
    latchByte = 8'h00;
    // bit 1 of the latch is unused, kept low
    latchByte[`PSCL_BIT_GAIN] = !((band == 3'(pscl_pkg::PSCL_BAND4)) || (band == 3'(pscl_pkg::PSCL_BAND5))); // RULE5 RULE6
    latchByte[`PSCL_BIT_DRIVE_EN] = filterUsed && !degauss; // RULE7 RULE8
    latchByte[`PSCL_BIT_SWEEP_INJ] = narrowSpan; // RULE9
    latchByte[`PSCL_BIT_FILT_PATH] = lowPass; // RULE10
    latchByte[`PSCL_BIT_OUT_FILT] = filterSwept; // RULE11
    // offsets: bands 2 and 4 minus, band 3 plus, band 5 none
    latchByte[`PSCL_BIT_NEG_IF] = (band == 3'(pscl_pkg::PSCL_BAND2)) || (band == 3'(pscl_pkg::PSCL_BAND4)); // RULE12 RULE14
    latchByte[`PSCL_BIT_POS_IF] = (band == 3'(pscl_pkg::PSCL_BAND3)); // RULE13 RULE14 RULE15
  end
endmodule

// ---- core/pscl_pkg.sv ----
// types shared by the filter drive latch controller
package pscl_pkg;
  // bus cycle sequencer states
  typedef enum logic [2:0] {PSCL_IDLE, PSCL_SETUP, PSCL_STROBE, PSCL_HOLD, PSCL_DONE} pscl_state_t;
  // band choices the user asks for
  typedef enum logic [2:0] {PSCL_BAND1, PSCL_BAND2, PSCL_BAND3, PSCL_BAND4, PSCL_BAND5} pscl_band_t;
endpackage

// ---- verification/pscl_ctrl_asserts.sv ----
// bus timing and result checks for the latch controller
`timescale 1ns/10ps
module pscl_ctrl_asserts
#(
  parameter int RELAY_CYCLES = 20
)
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       busy,
  input wire logic       doneOut,
  input wire logic       optionFitted,
  input wire logic       optionValid,
  input wire logic       relayPulse,
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busDataOut,
  input wire logic       busDataOe,
  input wire logic [7:0] busDataIn,
  input wire logic       busWrStrobe_n,
  input wire logic       busRdStrobe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int   relayCnt_ff;  // cycles since the relay pulse was last started
  logic wrPrev_ff;    // write strobe one cycle ago
  logic lastPath_ff;  // filter path last written
  logic pathKnown_ff; // a path has been written
  logic pathNew;      // a write that just ended changed the path
  assign pathNew = busWrStrobe_n && !wrPrev_ff && (!pathKnown_ff || (busDataOut[4] != lastPath_ff));
  // count cycles while the relay pulse is high, restarting on a path change
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      relayCnt_ff  <= 0;
      wrPrev_ff    <= 1'b1;
      lastPath_ff  <= 1'b0;
      pathKnown_ff <= 1'b0;
    end
    else
    begin
      wrPrev_ff <= busWrStrobe_n;
      if (busWrStrobe_n && !wrPrev_ff)
      begin
        lastPath_ff  <= busDataOut[4];
        pathKnown_ff <= 1'b1;
      end
      relayCnt_ff <= !relayPulse ? 0 : (pathNew ? 1 : relayCnt_ff + 1);
    end
  end
  ////////////////////////////////////////////////////////////////
  chk_wr_addr: assert property (!busWrStrobe_n |-> busAddr == 8'h77 && busDataOe)
    else $error("write strobe without latch address");
  chk_rd_addr: assert property (!busRdStrobe_n |-> busAddr == 8'hF7 && !busDataOe)
    else $error("read strobe without option address");
  chk_strobe_width: assert property ($fell(busWrStrobe_n) |-> ##9 !busWrStrobe_n ##1 busWrStrobe_n)
    else $error("write strobe width wrong");
  chk_data_held: assert property ($rose(busWrStrobe_n) |-> $stable(busDataOut) && busDataOe)
    else $error("data moved at latch edge");
  chk_done_time: assert property ($rose(busWrStrobe_n) |-> ##3 doneOut && !busy)
    else $error("completion timing wrong");
  chk_option_flag: assert property ($rose(busRdStrobe_n) |=> optionValid && optionFitted == !$past(busDataIn[4], 4))
    else $error("option flag wrong");
  chk_one_strobe: assert property (busWrStrobe_n || busRdStrobe_n)
    else $error("both strobes low");
  chk_relay_len: assert property ($fell(relayPulse) |-> relayCnt_ff == RELAY_CYCLES)
    else $error("relay pulse length wrong");
endmodule
bind pscl_ctrl pscl_ctrl_asserts #(.RELAY_CYCLES(RELAY_CYCLES)) i_pscl_ctrl_asserts
  (.clock(clock), .rst(rst), .busy(busy), .doneOut(doneOut), .optionFitted(optionFitted),
   .optionValid(optionValid), .relayPulse(relayPulse), .busAddr(busAddr), .busDataOut(busDataOut),
   .busDataOe(busDataOe), .busDataIn(busDataIn), .busWrStrobe_n(busWrStrobe_n),
   .busRdStrobe_n(busRdStrobe_n));

// ---- verification/pscl_dev_model.sv ----
// model of the drive board latch and option decoder on a pulled-up data bus
`timescale 1ns/10ps
module pscl_dev_model
(
  input  wire logic       optFitted,
  input  wire logic [7:0] busAddr,
  input  wire logic [7:0] busDataOut,
  input  wire logic       busDataOe,
  input  wire logic       busWrStrobe_n,
  input  wire logic       busRdStrobe_n,
  output logic      [7:0] busDataIn,
  output logic      [7:0] latchQ
);
  logic optSel; // option read decoded
  // whole byte taken at the strobe's trailing edge; bits drive the board
  always_ff @(posedge busWrStrobe_n)
    if (busAddr == 8'h77)
      latchQ <= busDataOut;
  assign optSel = !busRdStrobe_n && busAddr == 8'hF7;
  // only bit 4 is pulled low; other lines float to the pull-up level
  assign busDataIn = busDataOe ? busDataOut : ~{3'h0, optSel & optFitted, 4'h0};
endmodule

// ---- verification/tb_pscl_ctrl.sv ----
// self-checking bench for the latch controller
`timescale 1ns/10ps
module tb_pscl_ctrl;
  localparam int RELAY = 20; // short relay pulse for simulation
  logic       clock = 1'b0, rst = 1'b1, applyReq = 1'b0, probeReq = 1'b0, optFitted = 1'b0;
  logic       filterUsed = 1'b0, degauss = 1'b0, narrowSpan = 1'b0, filterSwept = 1'b0, lowPass = 1'b0;
  logic [2:0] band = 3'h0;
  logic       busy, doneOut, optionFitted, optionValid, relayPulse, busDataOe, busWrStrobe_n, busRdStrobe_n;
  logic [7:0] busAddr, busDataOut, busDataIn, latchQ;
  int         n_fail = 0, checks = 0, relayHigh = 0;
  pscl_ctrl #(.RELAY_CYCLES(RELAY)) i_pscl_ctrl (.clock(clock), .rst(rst), .applyReq(applyReq),
    .band(band), .filterUsed(filterUsed), .degauss(degauss), .narrowSpan(narrowSpan),
    .filterSwept(filterSwept), .lowPass(lowPass), .probeReq(probeReq), .busy(busy), .doneOut(doneOut),
    .optionFitted(optionFitted), .optionValid(optionValid), .relayPulse(relayPulse), .busAddr(busAddr),
    .busDataOut(busDataOut), .busDataOe(busDataOe), .busDataIn(busDataIn),
    .busWrStrobe_n(busWrStrobe_n), .busRdStrobe_n(busRdStrobe_n));
  pscl_dev_model i_pscl_dev_model (.optFitted(optFitted), .busAddr(busAddr), .busDataOut(busDataOut),
    .busDataOe(busDataOe), .busWrStrobe_n(busWrStrobe_n), .busRdStrobe_n(busRdStrobe_n),
    .busDataIn(busDataIn), .latchQ(latchQ));
  // free running clock and relay activity count
  initial forever #2 clock = ~clock;
  always @(posedge clock) relayHigh += (relayPulse === 1'b1);
  ////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    n_fail++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  // hold a request until taken, then wait for completion and idle
  task automatic run_op(input logic probe);
    int k;
    @(posedge clock); #1;
    if (probe) probeReq = 1'b1; else applyReq = 1'b1;
    for (k = 0; k < 40 && busy !== 1'b1; k++) begin @(posedge clock); #1; end
    probeReq = 1'b0;
    applyReq = 1'b0;
    for (k = 0; k < 40 && doneOut !== 1'b1; k++) begin @(posedge clock); #1; end
    @(posedge clock); #1;
    checks++;
    if (k == 40 || busy !== 1'b0) fail("operation did not complete");
  endtask
  // settings loop over every band and mixes of flags
  task automatic t_settings;
    logic [7:0] e;
    for (int i = 0; i < 10; i++)
    begin
      band = 3'(i % 5);
      {filterUsed, degauss, narrowSpan, filterSwept, lowPass} = 5'(i * 7);
      e = {band == 3'h2, band == 3'h1 || band == 3'h3, filterSwept, lowPass, narrowSpan,
           filterUsed & !degauss, 1'b0, band < 3'h3};
      run_op(1'b0);
      checks++;
      if (latchQ !== e) fail("latch byte wrong");
      checks++;
      if (latchQ[6] !== 1'b0 && latchQ[7] !== 1'b0) fail("both offsets set");
    end
    $display("settings test done");
  endtask
  // path change gives one pulse, an unchanged path none
  task automatic t_relay;
    for (int i = 0; i < 3; i++)
    begin
      repeat (RELAY + 10) @(posedge clock);
      #1;
      relayHigh = 0;
      lowPass = (i == 2) ? lowPass : ~lowPass;
      run_op(1'b0);
      repeat (RELAY + 10) @(posedge clock);
      #1;
      checks++;
      if (relayHigh != ((i == 2) ? 0 : RELAY)) fail("relay pulse wrong");
    end
    $display("relay test done");
  endtask
  // option read with board fitted and absent
  task automatic t_probe;
    for (int f = 1; f >= 0; f--)
    begin
      optFitted = 1'(f);
      run_op(1'b1);
      checks++;
      if (optionValid !== 1'b1 || optionFitted !== 1'(f)) fail("option status wrong");
    end
    $display("probe test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    #20000;
    fail("watchdog expired");
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    t_settings();
    t_relay();
    t_probe();
    close_out();
  end
endmodule
